// File: src/spms_port.sv
// Byte-wide serial peripheral port, master or slave
// How it works
// - Master drives SCK at programmed rate, idle level and phase.
// - Master and enable bits cleared whenever effective select is low in master role.
// - Master data write loads shift register, sends MSB first on MOSI.
// - Byte end sets done flag; interrupt when enabled and CPU mask clear.
// - Done flag clears after status access while set, then data access.
// - Data writes ignored while done flag set until status read.
// - Slave takes SCK in; data write loads byte for MISO, MSB first.
// - Slave transfer starts on master's clock with first bit on MOSI.
// - Polarity and phase pick one of four capture edge timings.
// - Select low in master sets mode fault, drops enable and master.
// - Mode fault clears on status read while set then control write.
// - Enable and master cannot be set while mode fault, except clearing write.
// - Byte done while flag set: overrun, keep first byte, clear on status read.
// - Data write during transfer discarded, sets collision flag, no interrupt.
// - Received bytes go to a buffer read without touching the shifter.
// - Wait mode runs normally; done, overrun or mode fault wakes the processor when interrupts are enabled.
// - Halt freezes registers except on mode fault; received bytes still set the done flag for wake-up.
// - Rate bits divide core clock by 4 to 128 in master role.
// - Phase 0 captures on first transition, phase 1 on second.
// - Polarity 0 idles SCK low, polarity 1 idles high.
// - Software select management replaces pin with software level.
`timescale 1ns/1ps
module spms_port #(
   parameter int FIFO_DEPTH = spms_pkg::RX_FIFO_DEPTH
) (
   input  wire logic       CORE_CLK_I,
   input  wire logic       ARST_N_I,
   input  wire logic       CTRL_WR_I,
   input  wire logic [7:0] CTRL_WDATA_I,
   input  wire logic       CSR_RD_I,
   input  wire logic       CSR_WR_I,
   input  wire logic [7:0] CSR_WDATA_I,
   input  wire logic       DATA_RD_I,
   input  wire logic       DATA_WR_I,
   input  wire logic [7:0] DATA_WDATA_I,
   input  wire logic       CPU_IRQ_MASK_I,
   input  wire logic       WAIT_MODE_I,
   input  wire logic       HALT_MODE_I,
   input  wire logic       SCK_I,
   input  wire logic       MOSI_I,
   input  wire logic       MISO_I,
   input  wire logic       SEL_N_I,
   input  wire logic       RX_READY_I,
   output logic [7:0]      CTRL_O,
   output logic [7:0]      CSR_O,
   output logic [7:0]      DATA_RDATA_O,
   output logic            IRQ_O,
   output logic            WAKE_O,
   output logic            SCK_O,
   output logic            SCK_OE_O,
   output logic            MOSI_O,
   output logic            MOSI_OE_O,
   output logic            MISO_O,
   output logic            MISO_OE_O,
   output logic [7:0]      RX_DATA_O,
   output logic            RX_VALID_O
);
   logic [7:0]                serial_control_reg;
   logic [7:0]                ctrl_next;
   logic [2:0]                sw_bits_reg;
   logic                      transfer_complete_flag;
   logic                      write_collision_flag;
   logic                      overrun_flag;
   logic                      mode_fault_flag;
   logic                      done_armed_reg;
   logic                      done_rd_reg;
   logic                      mode_fault_flag_armed_reg;
   logic                      write_collision_flag_armed_reg;
   logic [7:0]                serial_data_reg;
   logic [7:0]                shift_reg;
   logic                      out_bit_reg;
   logic                      cap_bit_reg;
   logic [2:0]                bit_cnt_reg;
   logic                      sck_lvl_reg;
   logic                      sck_norm_prev_reg;
   logic                      slave_busy_reg;
   spms_pkg::spms_mstate_type mstate_reg;

   logic       peripheral_enable;
   logic       master_select;
   logic       serial_interrupt_enable;
   logic       clock_polarity;
   logic       clock_phase;
   logic [2:0] rate_select;
   logic       select_software_management;
   logic       select_software_level;
   logic       out_disable;
   logic       sel_n;
   logic       is_master;
   logic       is_slave;
   logic       sck_norm;
   logic       tick;
   logic       lead;
   logic       trail;
   logic       din;
   logic       byte_done;
   logic [7:0] rx_byte;
   logic       busy;
   logic       sw_ok;
   logic       data_acc;
   logic       wr_blocked;
   logic       wr_load;
   logic       fault;

   spms_stream_if #(.WIDTH(spms_pkg::DATA_WIDTH)) rx_in ();
   spms_stream_if #(.WIDTH(spms_pkg::DATA_WIDTH)) rx_out ();

   assign peripheral_enable          = serial_control_reg[spms_pkg::CTL_ENABLE_BIT];
   assign master_select              = serial_control_reg[spms_pkg::CTL_MASTER_BIT];
   assign serial_interrupt_enable    = serial_control_reg[spms_pkg::CTL_IRQ_EN_BIT];
   assign clock_polarity             = serial_control_reg[spms_pkg::CTL_POL_BIT];
   assign clock_phase                = serial_control_reg[spms_pkg::CTL_PHASE_BIT];
   assign rate_select                = {serial_control_reg[spms_pkg::CTL_RATE2_BIT],
                                        serial_control_reg[spms_pkg::CTL_RATE1_BIT],
                                        serial_control_reg[spms_pkg::CTL_RATE0_BIT]};
   assign select_software_management = sw_bits_reg[spms_pkg::CSR_SW_SEL_BIT];
   assign select_software_level      = sw_bits_reg[spms_pkg::CSR_SW_LVL_BIT];
   assign out_disable                = sw_bits_reg[spms_pkg::CSR_OUT_DIS_BIT];

   // Effective select level
   assign sel_n     = select_software_management ? select_software_level : SEL_N_I;
   assign is_master = peripheral_enable & master_select;
   assign is_slave  = peripheral_enable & ~master_select;
   // Software strobes are dropped while halted so the registers stay frozen
   assign sw_ok     = ~HALT_MODE_I;
   assign fault     = is_master & ~sel_n;

   // Clock edges: leading is the first transition away from idle
   assign sck_norm = SCK_I ^ clock_polarity;
   assign lead  = is_master ? (tick & ~sck_lvl_reg & (mstate_reg == spms_pkg::M_RUN))
                            : (is_slave & ~sel_n & sck_norm & ~sck_norm_prev_reg);
   assign trail = is_master ? (tick & sck_lvl_reg & (mstate_reg == spms_pkg::M_RUN))
                            : (is_slave & ~sel_n & ~sck_norm & sck_norm_prev_reg);
   assign din   = is_master ? MISO_I : MOSI_I;
   assign byte_done = trail & (bit_cnt_reg == spms_pkg::LAST_BIT);
   assign rx_byte   = {shift_reg[6:0], clock_phase ? din : cap_bit_reg};

   // Phase 0 slave with select low is mid-byte: a write would collide
   assign busy = (mstate_reg != spms_pkg::M_IDLE) | slave_busy_reg
               | (is_slave & ~clock_phase & ~sel_n);
   assign data_acc   = sw_ok & (DATA_RD_I | DATA_WR_I);
   assign wr_blocked = transfer_complete_flag & ~done_rd_reg;
   assign wr_load    = sw_ok & DATA_WR_I & peripheral_enable & ~wr_blocked & ~busy;

   spms_rate_gen u_rate (
      .clk_i    (CORE_CLK_I),
      .arst_n_i (ARST_N_I),
      .run_i    ((mstate_reg == spms_pkg::M_RUN) & ~HALT_MODE_I),
      .half_i   (spms_pkg::half_period(rate_select)),
      .tick_o   (tick)
   );

   // Every byte with buffer room also leaves as a stream (a slave byte is dropped when full); a full buffer holds the master back
   assign rx_in.data   = rx_byte;
   assign rx_in.valid  = byte_done;
   assign rx_out.ready = RX_READY_I;
   assign RX_DATA_O    = rx_out.data;
   assign RX_VALID_O   = rx_out.valid;

   spms_fifo #(
      .WIDTH (spms_pkg::DATA_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i    (CORE_CLK_I),
      .arst_n_i (ARST_N_I),
      .in_s     (rx_in),
      .out_s    (rx_out)
   );

   // Control write: enable and master refused while a fault is pending
   always_comb
   begin
      ctrl_next = CTRL_WDATA_I;
      if (mode_fault_flag && !mode_fault_flag_armed_reg)
      begin
         ctrl_next[spms_pkg::CTL_ENABLE_BIT] = peripheral_enable
                                             & CTRL_WDATA_I[spms_pkg::CTL_ENABLE_BIT];
         ctrl_next[spms_pkg::CTL_MASTER_BIT] = master_select
                                             & CTRL_WDATA_I[spms_pkg::CTL_MASTER_BIT];
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         serial_control_reg <= spms_pkg::CTL_RESET;
      else if (fault)
      begin
         serial_control_reg[spms_pkg::CTL_ENABLE_BIT] <= 1'b0;
         serial_control_reg[spms_pkg::CTL_MASTER_BIT] <= 1'b0;
      end
      else if (sw_ok && CTRL_WR_I)
         serial_control_reg <= ctrl_next;
   end

   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         sw_bits_reg <= spms_pkg::CSR_RESET[2:0];
      else if (sw_ok && CSR_WR_I)
         sw_bits_reg <= CSR_WDATA_I[2:0] & spms_pkg::CSR_SW_MASK[2:0];
   end

   // Done flag and its two-step clear; a new byte end wins over the clear
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         transfer_complete_flag <= 1'b0;
         done_armed_reg         <= 1'b0;
         done_rd_reg            <= 1'b0;
      end
      else if (byte_done)
      begin
         transfer_complete_flag <= 1'b1;
         if (!transfer_complete_flag)
         begin
            done_armed_reg <= 1'b0;
            done_rd_reg    <= 1'b0;
         end
      end
      else if (transfer_complete_flag)
      begin
         if (data_acc && done_armed_reg)
         begin
            transfer_complete_flag <= 1'b0;
            done_armed_reg         <= 1'b0;
            done_rd_reg            <= 1'b0;
         end
         else if (sw_ok && (CSR_RD_I || CSR_WR_I))
         begin
            done_armed_reg <= 1'b1;
            if (CSR_RD_I)
               done_rd_reg <= 1'b1;
         end
      end
   end

   // Overrun: only a status read clears it
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         overrun_flag <= 1'b0;
      else if (byte_done && transfer_complete_flag)
         overrun_flag <= 1'b1;
      else if (sw_ok && CSR_RD_I)
         overrun_flag <= 1'b0;
   end

   // Mode fault: status read while set, then control write
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         mode_fault_flag <= 1'b0;
         mode_fault_flag_armed_reg  <= 1'b0;
      end
      else if (fault)
      begin
         mode_fault_flag <= 1'b1;
         mode_fault_flag_armed_reg  <= 1'b0;
      end
      else if (mode_fault_flag && sw_ok)
      begin
         if (CTRL_WR_I && mode_fault_flag_armed_reg)
         begin
            mode_fault_flag <= 1'b0;
            mode_fault_flag_armed_reg  <= 1'b0;
         end
         else if (CSR_RD_I)
            mode_fault_flag_armed_reg <= 1'b1;
      end
   end

   // Collision: status read, then data access
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         write_collision_flag <= 1'b0;
         write_collision_flag_armed_reg       <= 1'b0;
      end
      else if (sw_ok && DATA_WR_I && busy)
      begin
         write_collision_flag <= 1'b1;
         write_collision_flag_armed_reg       <= 1'b0;
      end
      else if (write_collision_flag && sw_ok)
      begin
         if (data_acc && write_collision_flag_armed_reg)
         begin
            write_collision_flag <= 1'b0;
            write_collision_flag_armed_reg       <= 1'b0;
         end
         else if (CSR_RD_I)
            write_collision_flag_armed_reg <= 1'b1;
      end
   end

   // Receive buffer keeps the first byte after the flag was cleared
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         serial_data_reg <= spms_pkg::DATA_RESET;
      else if (byte_done && !transfer_complete_flag)
         serial_data_reg <= rx_byte;
   end

   // Master sequencer; waits for buffer room so no byte is dropped
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         mstate_reg <= spms_pkg::M_IDLE;
      else if (!is_master)
         mstate_reg <= spms_pkg::M_IDLE;
      else
      begin
         unique case (mstate_reg)
            spms_pkg::M_IDLE:
               if (wr_load)
                  mstate_reg <= spms_pkg::M_WAIT;
            spms_pkg::M_WAIT:
               if (rx_in.ready && !HALT_MODE_I)
                  mstate_reg <= spms_pkg::M_RUN;
            spms_pkg::M_RUN:
               if (byte_done)
                  mstate_reg <= spms_pkg::M_IDLE;
         endcase
      end
   end

   // Normalised master clock level, 0 = idle
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         sck_lvl_reg <= 1'b0;
      else if (mstate_reg != spms_pkg::M_RUN)
         sck_lvl_reg <= 1'b0;
      else if (tick)
         sck_lvl_reg <= ~sck_lvl_reg;
   end

   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         sck_norm_prev_reg <= 1'b0;
      else
         sck_norm_prev_reg <= sck_norm;
   end

   // Slave is busy from its first clock edge to the byte end
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         slave_busy_reg <= 1'b0;
      else if (!is_slave || sel_n || byte_done)
         slave_busy_reg <= 1'b0;
      else if (lead)
         slave_busy_reg <= 1'b1;
   end

   // Shifter: phase 0 captures on leading, shifts on trailing;
   // phase 1 drives on leading, captures and shifts on trailing
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         shift_reg   <= spms_pkg::DATA_RESET;
         out_bit_reg <= 1'b0;
         cap_bit_reg <= 1'b0;
         bit_cnt_reg <= '0;
      end
      else if (wr_load)
      begin
         shift_reg   <= DATA_WDATA_I;
         out_bit_reg <= DATA_WDATA_I[7];
         bit_cnt_reg <= '0;
      end
      else if (!peripheral_enable || (is_slave && sel_n && !clock_phase))
         bit_cnt_reg <= '0;
      else if (lead)
      begin
         if (!clock_phase)
            cap_bit_reg <= din;
         else
            out_bit_reg <= shift_reg[7];
      end
      else if (trail)
      begin
         shift_reg   <= rx_byte;
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (!clock_phase)
            out_bit_reg <= shift_reg[6];
      end
   end

   // Pins, status and requests
   assign SCK_O     = sck_lvl_reg ^ clock_polarity;
   assign SCK_OE_O  = is_master;
   assign MOSI_O    = out_bit_reg;
   assign MOSI_OE_O = is_master & ~out_disable;
   assign MISO_O    = out_bit_reg;
   assign MISO_OE_O = is_slave & ~out_disable & ~sel_n;

   assign CTRL_O       = serial_control_reg;
   assign CSR_O        = {transfer_complete_flag, write_collision_flag, overrun_flag,
                          mode_fault_flag, 1'b0, sw_bits_reg};
   assign DATA_RDATA_O = serial_data_reg;
   // Collision is status only and raises nothing
   assign IRQ_O  = serial_interrupt_enable & ~CPU_IRQ_MASK_I
                 & (transfer_complete_flag | overrun_flag | mode_fault_flag);
   // Only the done event can end a halt
   assign WAKE_O = serial_interrupt_enable
                 & (HALT_MODE_I ? transfer_complete_flag
                                : (WAIT_MODE_I & (transfer_complete_flag | overrun_flag
                                                  | mode_fault_flag)));
endmodule : spms_port

// File: src/spms_pkg.sv
// Constants shared by the serial port blocks
package spms_pkg;
   // Control register bit positions
   localparam int unsigned CTL_IRQ_EN_BIT   = 7;
   localparam int unsigned CTL_ENABLE_BIT   = 6;
   localparam int unsigned CTL_RATE2_BIT    = 5;
   localparam int unsigned CTL_MASTER_BIT   = 4;
   localparam int unsigned CTL_POL_BIT      = 3;
   localparam int unsigned CTL_PHASE_BIT    = 2;
   localparam int unsigned CTL_RATE1_BIT    = 1;
   localparam int unsigned CTL_RATE0_BIT    = 0;
   localparam logic [7:0]  CTL_RESET        = 8'h00;
   // Control/status register bit positions
   localparam int unsigned CSR_DONE_BIT     = 7;
   localparam int unsigned CSR_WRITE_COLLISION_FLAG_BIT     = 6;
   localparam int unsigned CSR_OVR_BIT      = 5;
   localparam int unsigned CSR_MODE_FAULT_FLAG_BIT     = 4;
   localparam int unsigned CSR_OUT_DIS_BIT  = 2;
   localparam int unsigned CSR_SW_SEL_BIT   = 1;
   localparam int unsigned CSR_SW_LVL_BIT   = 0;
   localparam logic [7:0]  CSR_RESET        = 8'h00;
   localparam logic [7:0]  CSR_SW_MASK      = 8'h07;
   // Half periods of the master clock, in core cycles
   localparam logic [6:0]  HALF_DIV4        = 7'h02;
   localparam logic [6:0]  HALF_DIV8        = 7'h04;
   localparam logic [6:0]  HALF_DIV16       = 7'h08;
   localparam logic [6:0]  HALF_DIV32       = 7'h10;
   localparam logic [6:0]  HALF_DIV64       = 7'h20;
   localparam logic [6:0]  HALF_DIV128      = 7'h40;
   localparam int unsigned DATA_WIDTH       = 8;
   localparam int unsigned RX_FIFO_DEPTH    = 32;
   localparam logic [2:0]  LAST_BIT         = 3'h7;
   localparam logic [7:0]  DATA_RESET       = 8'h00;

   typedef enum logic [1:0] {M_IDLE, M_WAIT, M_RUN} spms_mstate_type;

   // Rate select {r2,r1,r0} to half period; unlisted codes take the slowest rate
   function automatic logic [6:0] half_period(input logic [2:0] rate);
      unique case (rate)
         3'b100:  half_period = HALF_DIV4;
         3'b000:  half_period = HALF_DIV8;
         3'b001:  half_period = HALF_DIV16;
         3'b110:  half_period = HALF_DIV32;
         3'b010:  half_period = HALF_DIV64;
         default: half_period = HALF_DIV128;
      endcase
   endfunction : half_period
endpackage : spms_pkg

// File: src/spms_stream_if.sv
// Valid/ready byte stream between the port and its buffer
`timescale 1ns/1ps
interface spms_stream_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : spms_stream_if

// File: src/spms_fifo.sv
// Synchronous FIFO for received bytes
`timescale 1ns/1ps
module spms_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic  clk_i,
   input  wire logic  arst_n_i,
   spms_stream_if.snk in_s,
   spms_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_s.ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_s.valid = (count_reg != '0);
   assign out_s.data  = mem_reg[rd_ptr_reg];
   assign push        = in_s.valid & in_s.ready;
   assign pop         = out_s.valid & out_s.ready;

   always_ff @(posedge clk_i)
   begin
      if (push)
         mem_reg[wr_ptr_reg] <= in_s.data;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         if (push && !pop)
            count_reg <= count_reg + 1'b1;
         else if (pop && !push)
            count_reg <= count_reg - 1'b1;
      end
   end
endmodule : spms_fifo

// File: src/spms_rate_gen.sv
// Half-period tick generator for the master serial clock
`timescale 1ns/1ps
module spms_rate_gen (
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       run_i,
   input  wire logic [6:0] half_i,
   output logic            tick_o
);
   logic [6:0] cnt_reg;

   assign tick_o = run_i && (cnt_reg == half_i - 7'h01);

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         cnt_reg <= '0;
      else if (!run_i || tick_o)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_reg + 7'h01;
   end
endmodule : spms_rate_gen

// File: testbench/spms_slave_model.sv
// Behavioural far-side slave for master transfers
`timescale 1ns/1ps
module spms_slave_model (
   input  wire logic       sck_i,
   input  wire logic       mosi_i,
   input  wire logic       pol_i,
   input  wire logic       pha_i,
   input  wire logic       ld_i,
   input  wire logic [7:0] tx_i,
   output logic            miso_o,
   output logic [7:0]      rx_o
);
   logic [7:0] sh_reg;
   wire        lead = sck_i ^ pol_i;
   // One process owns every output; inverted fill so a stale line never passes for data
   always @(posedge ld_i or posedge lead or negedge lead)
   begin
      if (ld_i)
      begin
         sh_reg = tx_i;
         miso_o = tx_i[7];
      end
      else if (lead)
      begin
         if (pha_i)
            miso_o = sh_reg[7];
         else
            rx_o = {rx_o[6:0], mosi_i};
      end
      else
      begin
         if (pha_i)
            rx_o = {rx_o[6:0], mosi_i};
         sh_reg = {sh_reg[6:0], ~sh_reg[7]};
         if (!pha_i)
            miso_o = sh_reg[7];
      end
   end
endmodule : spms_slave_model

// File: testbench/spms_port_monitor.sv
// Port-level assertions for the serial port
`timescale 1ns/1ps
module spms_port_monitor (
   input wire logic       CORE_CLK_I,
   input wire logic       ARST_N_I,
   input wire logic       CTRL_WR_I,
   input wire logic       CPU_IRQ_MASK_I,
   input wire logic       WAIT_MODE_I,
   input wire logic       HALT_MODE_I,
   input wire logic       SEL_N_I,
   input wire logic [7:0] CTRL_O,
   input wire logic [7:0] CSR_O,
   input wire logic [7:0] DATA_RDATA_O,
   input wire logic       IRQ_O,
   input wire logic       WAKE_O,
   input wire logic       SCK_O,
   input wire logic       SCK_OE_O,
   input wire logic       MOSI_OE_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!ARST_N_I);
   wire act    = CTRL_O[6] & CTRL_O[4];
   wire sel_lo = CSR_O[1] ? !CSR_O[0] : !SEL_N_I;
   wire ev     = CSR_O[7] | CSR_O[5] | CSR_O[4];
   property p_sck_oe; SCK_OE_O == act; endproperty
   a_sck_oe: assert property (p_sck_oe) else $error("clock enable wrong");
   property p_mosi_oe; MOSI_OE_O == (act & !CSR_O[2]); endproperty
   a_mosi_oe: assert property (p_mosi_oe) else $error("data enable wrong");
   property p_irq; IRQ_O == (CTRL_O[7] & !CPU_IRQ_MASK_I & ev); endproperty
   a_irq: assert property (p_irq) else $error("irq wrong");
   property p_mode_fault_flag; act && sel_lo && !HALT_MODE_I && !CTRL_WR_I |=> CSR_O[4] && !act; endproperty
   a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("fault not taken");
   property p_keep; CSR_O[7] && $past(CSR_O[7]) |-> $stable(DATA_RDATA_O); endproperty
   a_keep: assert property (p_keep) else $error("buffer overwritten");
   property p_halt; HALT_MODE_I && !sel_lo |=> $stable(CTRL_O); endproperty
   a_halt: assert property (p_halt) else $error("control moved in halt");
   property p_idle; $rose(CSR_O[7]) && CTRL_O[4] |-> SCK_O == CTRL_O[3]; endproperty
   a_idle: assert property (p_idle) else $error("clock not idle");
   property p_wake;
      WAKE_O == (CTRL_O[7] & (HALT_MODE_I ? CSR_O[7] : WAIT_MODE_I & ev)); endproperty
   a_wake: assert property (p_wake) else $error("wake wrong");
endmodule : spms_port_monitor
bind spms_port spms_port_monitor u_mon (.CORE_CLK_I, .ARST_N_I, .CTRL_WR_I, .CPU_IRQ_MASK_I,
   .WAIT_MODE_I, .HALT_MODE_I, .SEL_N_I, .CTRL_O, .CSR_O, .DATA_RDATA_O, .IRQ_O, .WAKE_O,
   .SCK_O, .SCK_OE_O, .MOSI_OE_O);

// File: testbench/tb_spms_port.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
module tb_spms_port;
   logic       clk = 0, rst_n = 0, cw = 0, crd = 0, cwr = 0, drd = 0, dwr = 0;
   logic       msk = 0, wt = 0, hlt = 0, sel_n = 1, rdy = 0, ld = 0, sck_s = 0, mosi_s = 0;
   logic [7:0] cwd = 0, swd = 0, dwd = 0, tx = 0, ctl, csr, rd, rx, srx;
   logic [7:0] exp_q [4];
   logic       irq, wake, sck, mosi, miso, rxv, so, soe;
   int         bad_count = 0, checks = 0, cyc = 0;
   // Small buffer so it fills within a few bytes
   spms_port #(.FIFO_DEPTH(4)) u_dut (.CORE_CLK_I(clk), .ARST_N_I(rst_n), .CTRL_WR_I(cw),
      .CTRL_WDATA_I(cwd), .CSR_RD_I(crd), .CSR_WR_I(cwr), .CSR_WDATA_I(swd), .DATA_RD_I(drd),
      .DATA_WR_I(dwr), .DATA_WDATA_I(dwd), .CPU_IRQ_MASK_I(msk), .WAIT_MODE_I(wt),
      .HALT_MODE_I(hlt), .SCK_I(sck_s), .MOSI_I(mosi_s), .MISO_I(miso), .SEL_N_I(sel_n),
      .RX_READY_I(rdy), .CTRL_O(ctl), .CSR_O(csr), .DATA_RDATA_O(rd), .IRQ_O(irq),
      .WAKE_O(wake), .SCK_O(sck), .SCK_OE_O(), .MOSI_O(mosi), .MOSI_OE_O(), .MISO_O(so),
      .MISO_OE_O(soe), .RX_DATA_O(rx), .RX_VALID_O(rxv));
   spms_slave_model u_far (.sck_i(sck), .mosi_i(mosi), .pol_i(ctl[3]), .pha_i(ctl[2]),
      .ld_i(ld), .tx_i(tx), .miso_o(miso), .rx_o(srx));
   initial forever #2 clk = ~clk;
   task results;
      $display("bad_count=%0d checks=%0d", bad_count, checks);
      if (bad_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         results;
      end
   end
   task chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task pulse(input int k, input logic [7:0] v);
      @(posedge clk);
      case (k)
         0: {cw, cwd} <= {1'b1, v};
         1: {cwr, swd} <= {1'b1, v};
         2: {dwr, dwd} <= {1'b1, v};
         3: crd <= 1'b1;
         default: drd <= 1'b1;
      endcase
      @(posedge clk);
      {cw, cwr, dwr, crd, drd} <= 5'h00;
      @(negedge clk);
   endtask : pulse
   task wait_done;
      int n;
      n = 0;
      while (csr[7] !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      chk({7'h00, csr[7]}, 8'h01);
   endtask : wait_done
   task start(input logic [7:0] b, input logic [7:0] s);
      tx = s;
      ld = 1;
      #1 ld = 0;
      pulse(2, b);
   endtask : start
   task xf(input logic [7:0] b, input logic [7:0] s);
      start(b, s);
      wait_done;
      chk(srx, b);
      chk(rd, s);
      pulse(3, 8'h00);
      pulse(4, 8'h00);
      chk(csr & 8'hF0, 8'h00);
   endtask : xf
   task t_master;
      pulse(1, 8'h03);
      pulse(0, 8'h70);
      chk(ctl, 8'h70);
      start(8'hA5, 8'h3C);
      pulse(2, 8'h11);
      wait_done;
      chk(srx, 8'hA5);
      chk(rd, 8'h3C);
      chk({7'h00, csr[6]}, 8'h01);
      pulse(2, 8'h22);
      repeat (40) @(posedge clk);
      chk(srx, 8'hA5);
      pulse(3, 8'h00);
      pulse(4, 8'h00);
      chk(csr, 8'h03);
   endtask : t_master
   task t_modes;
      exp_q[0] = 8'h3C;
      for (int m = 1; m < 4; m++)
      begin
         exp_q[m] = 8'hC3 ^ m[7:0];
         @(posedge clk) msk <= m[0];
         pulse(0, {4'hB, m[1:0], 2'b00});
         pulse(0, {4'hF, m[1:0], 2'b00});
         chk({7'h00, sck}, {7'h00, m[1]});
         xf(8'h5A ^ m[7:0], exp_q[m]);
      end
   endtask : t_modes
   task t_stall;
      @(posedge clk) wt <= 1'b1;
      start(8'h99, 8'h66);
      repeat (100) @(posedge clk);
      chk({6'h00, rxv, csr[7]}, 8'h02);
      @(posedge clk) rdy <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         @(negedge clk);
         chk(rx, exp_q[i]);
         @(posedge clk);
      end
      wait_done;
      chk({7'h00, wake}, 8'h01);
   endtask : t_stall
   task t_fault;
      pulse(3, 8'h00);
      pulse(4, 8'h00);
      @(posedge clk) sel_n <= 1'b0;
      pulse(1, 8'h00);
      @(negedge clk);
      chk({5'h00, csr[4], ctl[6], ctl[4]}, 8'h04);
      pulse(0, 8'h50);
      chk({5'h00, csr[4], ctl[6], ctl[4]}, 8'h04);
      @(posedge clk) sel_n <= 1'b1;
      pulse(3, 8'h00);
      pulse(0, 8'h50);
      chk({csr[4], ctl[6:0]}, 8'h50);
      @(posedge clk) hlt <= 1'b1;
      pulse(0, 8'h00);
      chk(ctl, 8'h50);
      @(posedge clk) hlt <= 1'b0;
   endtask : t_fault
   // Bench plays master: phase 1, select held low by software for the whole byte
   task t_slave;
      logic [7:0] sg;
      pulse(0, 8'h04);
      pulse(1, 8'h02);
      pulse(0, 8'h44);
      pulse(2, 8'hB4);
      for (int i = 7; i >= 0; i--)
      begin
         @(posedge clk) {sck_s, mosi_s} <= {1'b1, i[0]};
         repeat (3) @(posedge clk);
         sg = {sg[6:0], so};
         sck_s <= 1'b0;
         repeat (3) @(posedge clk);
      end
      wait_done;
      chk(sg, 8'hB4);
      chk(rd, 8'hAA);
      chk({7'h00, soe}, 8'h01);
   endtask : t_slave
   initial
   begin
      repeat (4) @(posedge clk);
      chk(ctl | csr, 8'h00);
      rst_n <= 1'b1;
      t_master;
      t_modes;
      t_stall;
      t_fault;
      t_slave;
      results;
   end
endmodule : tb_spms_port
